// ---- core/mcf_pkg.sv ----
// Package with constants and types of the machine-check frame builder.
package mcf_pkg;

  localparam logic [31:0] MCF_BYTE_COUNT      = 32'h0000_0010;
  localparam int          MCF_FRAME_WORDS     = 7;
  localparam logic [31:0] MCF_ADDR_STEP       = 32'h0000_0004;
  localparam logic [31:0] MCF_VEC_MCHK_OFFSET = 32'h0000_0004;
  localparam logic [4:0]  MCF_VTB_IPR_NUMBER  = 5'h11;
  localparam logic [3:0]  MCF_IS1_FIXED       = 4'hE;
  localparam logic [1:0]  MCF_IS2_FIXED_HI    = 2'h3;
  localparam logic [2:0]  MCF_IS2_FIXED_MID   = 3'h7;
  localparam logic [8:0]  MCF_VTB_ALIGN_BITS  = 9'h000;

  // Cause codes placed in the second longword of the frame.
  localparam logic [31:0] MCF_CODE_PTE_LOW_MISS   = 32'h0000_0005;
  localparam logic [31:0] MCF_CODE_PTE_HIGH_MISS  = 32'h0000_0006;
  localparam logic [31:0] MCF_CODE_PTE_LOW_MOD    = 32'h0000_0007;
  localparam logic [31:0] MCF_CODE_PTE_HIGH_MOD   = 32'h0000_0008;
  localparam logic [31:0] MCF_CODE_UNUSED_LEVEL   = 32'h0000_0009;
  localparam logic [31:0] MCF_CODE_STRING_STATE   = 32'h0000_000A;
  localparam logic [31:0] MCF_CODE_READ_VIRT      = 32'h0000_0080;
  localparam logic [31:0] MCF_CODE_READ_PHYS      = 32'h0000_0081;
  localparam logic [31:0] MCF_CODE_WRITE_VIRT     = 32'h0000_0082;
  localparam logic [31:0] MCF_CODE_WRITE_PHYS     = 32'h0000_0083;

  // Cause reported by the core's execution and memory logic.
  typedef enum logic [3:0] {
    MCF_CAUSE_PTE_MISS,
    MCF_CAUSE_PTE_MODIFY,
    MCF_CAUSE_UNUSED_LEVEL,
    MCF_CAUSE_STRING_STATE,
    MCF_CAUSE_READ_OPERAND,
    MCF_CAUSE_READ_PROC_PTE,
    MCF_CAUSE_READ_INTERLOCK,
    MCF_CAUSE_READ_SYS_PTE,
    MCF_CAUSE_READ_CONTEXT,
    MCF_CAUSE_READ_VECTOR,
    MCF_CAUSE_WRITE_OPERAND,
    MCF_CAUSE_WRITE_PROC_PTE,
    MCF_CAUSE_WRITE_SYS_PTE,
    MCF_CAUSE_WRITE_CONTEXT
  } mcf_cause_t;

  // Region a computed process page-table entry address fell in.
  typedef enum logic [1:0] {
    MCF_REGION_SYSTEM,
    MCF_REGION_LOW_PROCESS,
    MCF_REGION_HIGH_PROCESS
  } mcf_region_t;

  // Frame slot index, lowest address first.
  localparam logic [2:0] MCF_SLOT_COUNT  = 3'h0;
  localparam logic [2:0] MCF_SLOT_CODE   = 3'h1;
  localparam logic [2:0] MCF_SLOT_ADDR   = 3'h2;
  localparam logic [2:0] MCF_SLOT_STATE1 = 3'h3;
  localparam logic [2:0] MCF_SLOT_STATE2 = 3'h4;
  localparam logic [2:0] MCF_SLOT_PC     = 3'h5;
  localparam logic [2:0] MCF_SLOT_STATUS = 3'h6;

endpackage

// ---- core/mcf_frame_mem.sv ----
// Small frame memory holding the seven longwords of one machine-check frame.
`timescale 1ns/1ps
`default_nettype none
module mcf_frame_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 7,
  parameter int AW    = 3
) (
  input  wire logic             mclk,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rd_data_reg;

  // Read data leaves through a register so the push path sees a clean word.
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;

endmodule
`default_nettype wire

// ---- core/mcf_frame_builder.sv ----
// Machine-check frame builder: classifies the cause, captures and pushes the frame.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Push status, program counter, four parameters and a byte count on machine check.
// RULE2: Byte count longword is 16, excluding program counter and status.
// RULE3: A 32-bit cause code identifies the kind of machine check.
// RULE4: Page-table miss reports 5 for low process region, 6 for high.
// RULE5: Modified-bit update reports 7 for low process region, 8 for high.
// RULE6: Interrupt at an unused priority level gives non-recoverable code 9.
// RULE7: Impossible string-move state reports code A.
// RULE8: Operand, process entry or interlocked read errors report code 80.
// RULE9: System entry, context or vector-table read errors report code 81.
// RULE10: Operand or process entry modified-bit write errors report code 82.
// RULE11: System entry modified-bit or context write errors report code 83.
// RULE12: Software treats read errors recoverable by partial-done and cannot-restart flags.
// RULE13: Software treats write errors as non-recoverable.
// RULE14: Read errors capture read address plus four; physical only for 81.
// RULE15: Write errors capture referenced address plus four; physical only for 83.
// RULE16: First state: opcode on top, then 1110 over pending software level.
// RULE17: First state: cache control low byte, then memory error low byte.
// RULE18: Second state: step count low byte, then 11 over six state flags.
// RULE19: Second state: cannot-restart at bit 15, then 111 over condition codes.
// RULE20: Second state low byte is access address minus instruction start.
// RULE21: Stacked counter is instruction start; status longword stacked whole.
// RULE22: Vectors dispatch through a two-page table located by register 17.
// RULE23: Byte count lowest, then code, address, states, counter, status upward.
module mcf_frame_builder
  import mcf_pkg::*;
#(
  parameter int AW = 32
) (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     mchk_req,
  input  wire mcf_pkg::mcf_cause_t      mchk_cause,
  input  wire mcf_pkg::mcf_region_t     pte_region,
  input  wire logic [AW-1:0]            access_addr,
  input  wire logic [AW-1:0]            access_phys_addr,
  input  wire logic [7:0]               opcode,
  input  wire logic [3:0]               sw_int_pending,
  input  wire logic [7:0]               cache_control_register,
  input  wire logic [7:0]               memory_system_error_register,
  input  wire logic [7:0]               step_count_register,
  input  wire logic [5:0]               state_flags,
  input  wire logic                     cannot_restart_flag,
  input  wire logic [3:0]               cond_codes,
  input  wire logic [AW-1:0]            instr_start_pc,
  input  wire logic [31:0]              processor_status_longword,
  input  wire logic [AW-1:0]            stack_pointer,
  input  wire logic                     vtb_wr,
  input  wire logic [AW-1:0]            vtb_wdata,
  output logic      [AW-1:0]            vtb_base,
  output logic      [AW-1:0]            mchk_vector_addr,
  output logic                          busy,
  output logic                          push_valid,
  input  wire logic                     push_ready,
  output logic      [AW-1:0]            push_addr,
  output logic      [31:0]              push_data,
  output logic                          frame_done,
  output logic      [31:0]              last_code,
  output logic                          last_recover_hint
);
  import mcf_pkg::*;

  // ****************************************************************
  // Cause classification
  // ****************************************************************

  function automatic logic [31:0] cause_code(input mcf_cause_t c, input mcf_region_t r);
    logic [31:0] code;
    code = MCF_CODE_READ_VIRT;
    case (c)
      MCF_CAUSE_PTE_MISS: begin
        code = (r == MCF_REGION_HIGH_PROCESS) ? MCF_CODE_PTE_HIGH_MISS
                                              : MCF_CODE_PTE_LOW_MISS; // RULE4
      end
      MCF_CAUSE_PTE_MODIFY: begin
        code = (r == MCF_REGION_HIGH_PROCESS) ? MCF_CODE_PTE_HIGH_MOD
                                              : MCF_CODE_PTE_LOW_MOD; // RULE5
      end
      MCF_CAUSE_UNUSED_LEVEL:   code = MCF_CODE_UNUSED_LEVEL; // RULE6
      MCF_CAUSE_STRING_STATE:   code = MCF_CODE_STRING_STATE; // RULE7
      MCF_CAUSE_READ_OPERAND,
      MCF_CAUSE_READ_PROC_PTE,
      MCF_CAUSE_READ_INTERLOCK: code = MCF_CODE_READ_VIRT; // RULE8
      MCF_CAUSE_READ_SYS_PTE,
      MCF_CAUSE_READ_CONTEXT,
      MCF_CAUSE_READ_VECTOR:    code = MCF_CODE_READ_PHYS; // RULE9
      MCF_CAUSE_WRITE_OPERAND,
      MCF_CAUSE_WRITE_PROC_PTE: code = MCF_CODE_WRITE_VIRT; // RULE10
      MCF_CAUSE_WRITE_SYS_PTE,
      MCF_CAUSE_WRITE_CONTEXT:  code = MCF_CODE_WRITE_PHYS; // RULE11
      default:                  code = MCF_CODE_READ_VIRT;
    endcase
    return code;
  endfunction

  function automatic logic is_read_cause(input mcf_cause_t c);
    return (c == MCF_CAUSE_READ_OPERAND) || (c == MCF_CAUSE_READ_PROC_PTE) ||
           (c == MCF_CAUSE_READ_INTERLOCK) || (c == MCF_CAUSE_READ_SYS_PTE) ||
           (c == MCF_CAUSE_READ_CONTEXT) || (c == MCF_CAUSE_READ_VECTOR);
  endfunction

  logic [31:0] new_code;
  logic        uses_phys;
  logic [31:0] new_addr;
  logic [31:0] new_state1;
  logic [31:0] new_state2;
  logic [7:0]  pc_offset;

  assign new_code  = cause_code(mchk_cause, pte_region); // RULE3
  // Only the two physical-address codes capture the physical pointer.
  assign uses_phys = (new_code == MCF_CODE_READ_PHYS) || (new_code == MCF_CODE_WRITE_PHYS);
  assign new_addr  = (uses_phys ? access_phys_addr : access_addr) + MCF_ADDR_STEP; // RULE14 RULE15
  assign pc_offset = 8'(access_addr - instr_start_pc); // RULE20
  assign new_state1 = {opcode, MCF_IS1_FIXED, sw_int_pending,
                       cache_control_register, memory_system_error_register}; // RULE16 RULE17
  assign new_state2 = {step_count_register, MCF_IS2_FIXED_HI, state_flags,
                       cannot_restart_flag, MCF_IS2_FIXED_MID, cond_codes,
                       pc_offset}; // RULE18 RULE19 RULE20

  // ****************************************************************
  // Vector table base
  // ****************************************************************

  logic [AW-1:0] vtb_reg;
  logic [AW-1:0] vtb_next;

  // The table spans two pages, so the base keeps page alignment.
  always_comb begin
    vtb_next = vtb_reg;
    if (vtb_wr) begin
      vtb_next = {vtb_wdata[AW-1:9], MCF_VTB_ALIGN_BITS}; // RULE22
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      vtb_reg <= '0;
    end else if (ce) begin
      vtb_reg <= vtb_next;
    end
  end

  assign vtb_base         = vtb_reg;
  assign mchk_vector_addr = vtb_reg + MCF_VEC_MCHK_OFFSET; // RULE22

  // ****************************************************************
  // Capture and push sequencer
  // ****************************************************************

  typedef enum {
    MCF_ST_IDLE,
    MCF_ST_FILL,
    MCF_ST_READ,
    MCF_ST_PUSH,
    MCF_ST_DONE
  } mcf_state_t;

  mcf_state_t    state_reg,  state_next;
  logic [2:0]    slot_reg,   slot_next;
  logic [AW-1:0] base_reg,   base_next;
  logic [31:0]   code_reg,   code_next;
  logic          hint_reg,   hint_next;
  logic [31:0]   cap_addr_reg, cap_addr_next;
  logic [31:0]   cap_s1_reg,   cap_s1_next;
  logic [31:0]   cap_s2_reg,   cap_s2_next;
  logic [31:0]   cap_pc_reg,   cap_pc_next;
  logic [31:0]   cap_psl_reg,  cap_psl_next;
  logic          mem_wr;
  logic [31:0]   mem_wdata;
  logic [31:0]   mem_rdata;

  function automatic logic [31:0] slot_word(input logic [2:0] s, input logic [31:0] cd,
                                            input logic [31:0] ad, input logic [31:0] s1,
                                            input logic [31:0] s2, input logic [31:0] pc,
                                            input logic [31:0] ps);
    logic [31:0] w;
    w = MCF_BYTE_COUNT;
    case (s)
      MCF_SLOT_COUNT:  w = MCF_BYTE_COUNT; // RULE2
      MCF_SLOT_CODE:   w = cd;
      MCF_SLOT_ADDR:   w = ad;
      MCF_SLOT_STATE1: w = s1;
      MCF_SLOT_STATE2: w = s2;
      MCF_SLOT_PC:     w = pc; // RULE21
      MCF_SLOT_STATUS: w = ps; // RULE21
      default:         w = MCF_BYTE_COUNT;
    endcase
    return w;
  endfunction

  always_comb begin
    state_next    = state_reg;
    slot_next     = slot_reg;
    base_next     = base_reg;
    code_next     = code_reg;
    hint_next     = hint_reg;
    cap_addr_next = cap_addr_reg;
    cap_s1_next   = cap_s1_reg;
    cap_s2_next   = cap_s2_reg;
    cap_pc_next   = cap_pc_reg;
    cap_psl_next  = cap_psl_reg;
    mem_wr        = 1'b0;
    mem_wdata     = slot_word(slot_reg, code_reg, cap_addr_reg, cap_s1_reg,
                              cap_s2_reg, cap_pc_reg, cap_psl_reg);
    case (state_reg)
      MCF_ST_IDLE: begin
        if (mchk_req) begin
          // Snapshot everything in the cycle of the request, so later core
          // activity cannot leak into the frame.
          code_next     = new_code;
          cap_addr_next = new_addr;
          cap_s1_next   = new_state1;
          cap_s2_next   = new_state2;
          cap_pc_next   = instr_start_pc; // RULE21
          cap_psl_next  = processor_status_longword; // RULE21
          // Only read errors can be recovered; software decides finally.
          hint_next     = is_read_cause(mchk_cause) & ~cannot_restart_flag; // RULE12 RULE13
          base_next     = stack_pointer - AW'(MCF_FRAME_WORDS * 4); // RULE23
          slot_next     = MCF_SLOT_COUNT;
          state_next    = MCF_ST_FILL;
        end
      end
      MCF_ST_FILL: begin
        mem_wr = 1'b1;
        if (slot_reg == MCF_SLOT_STATUS) begin
          slot_next  = MCF_SLOT_COUNT;
          state_next = MCF_ST_READ;
        end else begin
          slot_next = slot_reg + 3'h1;
        end
      end
      MCF_ST_READ: begin
        state_next = MCF_ST_PUSH;
      end
      MCF_ST_PUSH: begin
        if (push_ready) begin
          if (slot_reg == MCF_SLOT_STATUS) begin
            state_next = MCF_ST_DONE; // RULE1
          end else begin
            slot_next  = slot_reg + 3'h1;
            state_next = MCF_ST_READ;
          end
        end
      end
      MCF_ST_DONE: begin
        state_next = MCF_ST_IDLE;
      end
      default: begin
        state_next = MCF_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg    <= MCF_ST_IDLE;
      slot_reg     <= MCF_SLOT_COUNT;
      base_reg     <= '0;
      code_reg     <= '0;
      hint_reg     <= 1'b0;
      cap_addr_reg <= '0;
      cap_s1_reg   <= '0;
      cap_s2_reg   <= '0;
      cap_pc_reg   <= '0;
      cap_psl_reg  <= '0;
    end else if (ce) begin
      state_reg    <= state_next;
      slot_reg     <= slot_next;
      base_reg     <= base_next;
      code_reg     <= code_next;
      hint_reg     <= hint_next;
      cap_addr_reg <= cap_addr_next;
      cap_s1_reg   <= cap_s1_next;
      cap_s2_reg   <= cap_s2_next;
      cap_pc_reg   <= cap_pc_next;
      cap_psl_reg  <= cap_psl_next;
    end
  end

  mcf_frame_mem #(
    .WIDTH (32),
    .DEPTH (MCF_FRAME_WORDS),
    .AW    (3)
  ) u_frame_mem (
    .mclk    (mclk),
    .ce      (ce),
    .wr_en   (mem_wr),
    .wr_addr (slot_reg),
    .wr_data (mem_wdata),
    .rd_addr (slot_reg),
    .rd_data (mem_rdata)
  );

  assign busy       = (state_reg != MCF_ST_IDLE);
  assign push_valid = (state_reg == MCF_ST_PUSH);
  assign push_data  = mem_rdata;
  assign push_addr  = base_reg + AW'({slot_reg, 2'b00}); // RULE23
  assign frame_done = (state_reg == MCF_ST_DONE);
  assign last_code  = code_reg;
  assign last_recover_hint = hint_reg;

endmodule
`default_nettype wire

// ---- verification/mcf_frame_builder_checker.sv ----
// Concurrent property checker for the machine-check frame builder ports.
`timescale 1ns/1ps
`default_nettype none
module mcf_frame_builder_checker
  import mcf_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic          mclk,
  input wire logic          reset,
  input wire logic          ce,
  input wire logic          mchk_req,
  input wire logic          busy,
  input wire logic          push_valid,
  input wire logic          push_ready,
  input wire logic [AW-1:0] push_addr,
  input wire logic [31:0]   push_data,
  input wire logic          frame_done,
  input wire logic [AW-1:0] vtb_base,
  input wire logic [AW-1:0] mchk_vector_addr,
  input wire logic [31:0]   last_code,
  input wire logic          last_recover_hint
);
  import mcf_pkg::*;
  logic          take;
  logic [3:0]    cnt_reg;
  logic [AW-1:0] prev_reg;

  assign take = ce && mchk_req && !busy;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Accepted words since the last taken request; the gap check needs the previous address.
  always_ff @(posedge mclk) begin
    if (reset || take) begin
      cnt_reg <= 4'h0;
    end else if (push_valid && push_ready) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    if (push_valid && push_ready) begin
      prev_reg <= push_addr;
    end
  end

  a_take_sets_busy: assert property (take |=> busy)
    else $error("busy did not rise after a taken request");
  a_count_word_first: assert property (take |-> ##9 (push_valid && push_data == MCF_BYTE_COUNT))
    else $error("first pushed word is not the byte count");
  a_word_held: assert property (push_valid && !push_ready |=> push_valid && $stable(push_addr) && $stable(push_data))
    else $error("pushed word changed before acceptance");
  a_addr_ascends: assert property ($rose(push_valid) && cnt_reg != 4'h0 |-> push_addr == prev_reg + MCF_ADDR_STEP)
    else $error("push address did not step up by four");
  a_seven_words: assert property (frame_done |-> cnt_reg == 4'h7)
    else $error("frame finished without seven words");
  a_done_pulse: assert property (frame_done |=> !frame_done && !busy)
    else $error("frame done not a single pulse followed by idle");
  a_vector_offset: assert property (mchk_vector_addr == vtb_base + MCF_VEC_MCHK_OFFSET)
    else $error("machine check vector address wrong");
  a_write_no_hint: assert property (frame_done && last_code[7:1] == 7'h41 |-> !last_recover_hint)
    else $error("write error marked recoverable");
  a_level_no_hint: assert property (frame_done && last_code == MCF_CODE_UNUSED_LEVEL |-> !last_recover_hint)
    else $error("unused level error marked recoverable");
endmodule
bind mcf_frame_builder mcf_frame_builder_checker #(.AW(AW)) u_mcf_frame_builder_checker (
  .mclk(mclk), .reset(reset), .ce(ce), .mchk_req(mchk_req), .busy(busy),
  .push_valid(push_valid), .push_ready(push_ready), .push_addr(push_addr),
  .push_data(push_data), .frame_done(frame_done), .vtb_base(vtb_base),
  .mchk_vector_addr(mchk_vector_addr), .last_code(last_code),
  .last_recover_hint(last_recover_hint)
);
`default_nettype wire

// ---- verification/mcf_frame_builder_tb.sv ----
// Self-checking testbench for the machine-check frame builder.
`timescale 1ns/1ps
`default_nettype none
module mcf_frame_builder_tb;
  import mcf_pkg::*;
  logic        mclk, busy, push_valid, frame_done, last_recover_hint;
  logic        reset = 1'b1, ce = 1'b1, mchk_req = 1'b0, vtb_wr = 1'b0, push_ready = 1'b0;
  logic        cannot_restart_flag = 1'b0;
  mcf_cause_t  mchk_cause = MCF_CAUSE_PTE_MISS;
  mcf_region_t pte_region = MCF_REGION_SYSTEM;
  logic [31:0] access_addr = 32'h0, access_phys_addr = 32'h0, instr_start_pc = 32'h0;
  logic [31:0] processor_status_longword = 32'h0, stack_pointer = 32'h0, vtb_wdata = 32'h0;
  logic [31:0] vtb_base, mchk_vector_addr, push_addr, push_data, last_code;
  logic [7:0]  opcode = 8'h0, cache_control_register = 8'h0;
  logic [7:0]  memory_system_error_register = 8'h0, step_count_register = 8'h0;
  logic [5:0]  state_flags = 6'h0;
  logic [3:0]  sw_int_pending = 4'h0, cond_codes = 4'h0;
  int          bad_count = 0, n_tests = 0;

  mcf_frame_builder #(.AW(32)) u_mcf_frame_builder (
    .mclk, .reset, .ce, .mchk_req, .mchk_cause, .pte_region, .access_addr, .access_phys_addr,
    .opcode, .sw_int_pending, .cache_control_register, .memory_system_error_register,
    .step_count_register, .state_flags, .cannot_restart_flag, .cond_codes, .instr_start_pc,
    .processor_status_longword, .stack_pointer, .vtb_wr, .vtb_wdata, .vtb_base,
    .mchk_vector_addr, .busy, .push_valid, .push_ready, .push_addr, .push_data, .frame_done,
    .last_code, .last_recover_hint
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic t_reset;
    chk("busy", {31'h0, busy}, 32'h0);
    chk("push_valid", {31'h0, push_valid}, 32'h0);
    chk("vtb_base", vtb_base, 32'h0);
    chk("vector", mchk_vector_addr, 32'h4);
    chk("last_code", last_code, 32'h0);
  endtask

  // The base is kept page aligned, so the low nine written bits must vanish.
  task automatic t_vtb;
    ce = 1'b0;
    vtb_wr = 1'b1;
    vtb_wdata = 32'hFFFF_FFFF;
    @(negedge mclk);
    chk("vtb_frozen", vtb_base, 32'h0);
    ce = 1'b1;
    vtb_wdata = 32'h1234_5FFF;
    @(negedge mclk);
    vtb_wr = 1'b0;
    chk("vtb_base", vtb_base, 32'h1234_5E00);
    chk("vector", mchk_vector_addr, 32'h1234_5E04);
  endtask

  // One frame with stalls on odd words and a refused request while busy.
  task automatic t_frame(input int i, input mcf_cause_t c, input mcf_region_t r,
                         input logic [31:0] code);
    logic [31:0] w [7];
    logic [31:0] got [7];
    int          k;
    int          t;
    mchk_cause = c;
    pte_region = r;
    access_addr = 32'h4000_0100 + 32'(i * 16);
    access_phys_addr = 32'h0010_0000 + 32'(i * 8);
    instr_start_pc = access_addr - 32'(i + 1);
    opcode = 8'(8'h10 + i);
    sw_int_pending = 4'(i);
    step_count_register = 8'(8'h20 + i);
    state_flags = 6'(i * 3);
    cannot_restart_flag = i[0];
    cond_codes = 4'(15 - i);
    cache_control_register = 8'(8'hC0 ^ i);
    memory_system_error_register = 8'(8'h5A + i);
    processor_status_longword = 32'h041F_0000 + 32'(i);
    stack_pointer = 32'h0000_8000 + 32'(i * 256);
    mchk_req = 1'b1;
    w[1] = code;
    w[2] = ((code == MCF_CODE_READ_PHYS || code == MCF_CODE_WRITE_PHYS) ?
            access_phys_addr : access_addr) + MCF_ADDR_STEP;
    w[3] = {opcode, MCF_IS1_FIXED, sw_int_pending, cache_control_register,
            memory_system_error_register};
    w[4] = {step_count_register, MCF_IS2_FIXED_HI, state_flags, cannot_restart_flag,
            MCF_IS2_FIXED_MID, cond_codes, 8'(access_addr - instr_start_pc)};
    @(negedge mclk);
    mchk_req = 1'b0;
    for (k = 0; k < 7; k++) begin
      t = 0;
      while (push_valid !== 1'b1 && t < 40) begin
        @(negedge mclk);
        t++;
      end
      got[k] = push_data;
      chk("push_addr", push_addr, stack_pointer - 32'h1C + 32'(4 * k));
      mchk_req = (k == 3);
      if (k % 2 == 1) begin
        repeat (2) @(negedge mclk);
      end
      push_ready = 1'b1;
      @(negedge mclk);
      push_ready = 1'b0;
      mchk_req = 1'b0;
    end
    chk("count", got[0], MCF_BYTE_COUNT);
    chk("code", got[1], w[1]);
    if (code[7]) begin
      chk("recent_addr", got[2], w[2]);
    end
    chk("state1", got[3], w[3]);
    chk("state2", got[4], w[4]);
    chk("pc", got[5], instr_start_pc);
    chk("status", got[6], processor_status_longword);
    t = 0;
    while (frame_done !== 1'b1 && t < 4) begin
      @(negedge mclk);
      t++;
    end
    chk("frame_done", {31'h0, frame_done}, 32'h1);
    chk("last_code", last_code, code);
    chk("hint", {31'h0, last_recover_hint},
        {31'h0, code[7] && !code[1] && !cannot_restart_flag});
    @(negedge mclk);
    chk("busy_after", {31'h0, busy}, 32'h0);
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_reset;
    t_vtb;
    t_frame(0, MCF_CAUSE_PTE_MISS, MCF_REGION_LOW_PROCESS, MCF_CODE_PTE_LOW_MISS);
    t_frame(1, MCF_CAUSE_PTE_MISS, MCF_REGION_HIGH_PROCESS, MCF_CODE_PTE_HIGH_MISS);
    t_frame(2, MCF_CAUSE_PTE_MODIFY, MCF_REGION_LOW_PROCESS, MCF_CODE_PTE_LOW_MOD);
    t_frame(3, MCF_CAUSE_PTE_MODIFY, MCF_REGION_HIGH_PROCESS, MCF_CODE_PTE_HIGH_MOD);
    t_frame(4, MCF_CAUSE_UNUSED_LEVEL, MCF_REGION_SYSTEM, MCF_CODE_UNUSED_LEVEL);
    t_frame(5, MCF_CAUSE_STRING_STATE, MCF_REGION_SYSTEM, MCF_CODE_STRING_STATE);
    t_frame(6, MCF_CAUSE_READ_OPERAND, MCF_REGION_SYSTEM, MCF_CODE_READ_VIRT);
    t_frame(7, MCF_CAUSE_READ_PROC_PTE, MCF_REGION_SYSTEM, MCF_CODE_READ_VIRT);
    t_frame(8, MCF_CAUSE_READ_INTERLOCK, MCF_REGION_SYSTEM, MCF_CODE_READ_VIRT);
    t_frame(9, MCF_CAUSE_READ_SYS_PTE, MCF_REGION_SYSTEM, MCF_CODE_READ_PHYS);
    t_frame(10, MCF_CAUSE_READ_CONTEXT, MCF_REGION_SYSTEM, MCF_CODE_READ_PHYS);
    t_frame(11, MCF_CAUSE_READ_VECTOR, MCF_REGION_SYSTEM, MCF_CODE_READ_PHYS);
    t_frame(12, MCF_CAUSE_WRITE_OPERAND, MCF_REGION_SYSTEM, MCF_CODE_WRITE_VIRT);
    t_frame(13, MCF_CAUSE_WRITE_PROC_PTE, MCF_REGION_SYSTEM, MCF_CODE_WRITE_VIRT);
    t_frame(14, MCF_CAUSE_WRITE_SYS_PTE, MCF_REGION_SYSTEM, MCF_CODE_WRITE_PHYS);
    t_frame(15, MCF_CAUSE_WRITE_CONTEXT, MCF_REGION_SYSTEM, MCF_CODE_WRITE_PHYS);
    report_and_stop;
  end
endmodule
`default_nettype wire
